// file: rtl/serdes_tx_setting_selector.sv
// Purpose: Per-lane SerDes transmit and receiver setting selection
// Assumes: APB with zero wait states; gen2_i is on clk_i
// Notes: Read data is latched in the setup cycle
`timescale 1ns/10ps
`default_nettype none

// Contract
// - Low swing drives lanes at about half the full-swing level.
// - Low swing forces zero de-emphasis, ignoring the de-emphasis select bit.
// - Low swing switches all lanes of a port together.
// - Per-lane receiver equalizer settings, writable at any time.
// - Control registers writable from root, boot load and management port.
// - Each quad has its own pair of lane transmit control registers.
// - Normal margin value takes lane voltage from the quad registers.
// - Other margin values set all lanes of the port directly.
// - Merged port applies lower port margin selection to both quads.
// - Nominal de-emphasis offset by coarse and fine quad fields.
// - Lane-select register steers writes to one lane or all lanes.
// - Separate setting fields for five swing, rate and de-emphasis modes.
// - Mode fields reset to suitable defaults, software may overwrite.
// - Physical mode change switches to the new mode's field set.
// - Field groups per mode; slew by rate; low swing drive plus slew.
// - Changed settings reach the SerDes without link retraining.
// - Ports 0,1,4,5 map port lane n to quad lane 3-n.
// - Merged port joins an even port with its odd neighbour.
module serdes_tx_setting_selector #(
    parameter int QUADS = 8,
    parameter int LANES = 4,
    parameter logic [7:0] REVERSED = 8'h33
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Register bus
    input wire serdes_pkg::apb_req_t apb_i,
    output var serdes_pkg::apb_rsp_t apb_o,
    // Physical layer rate per port
    input wire logic [QUADS-1:0] gen2_i,
    // SerDes lanes, quad-major
    output var serdes_pkg::tx_setting_t [QUADS*LANES-1:0] tx_o,
    output var logic [QUADS*LANES-1:0][`RX_EQ_W-1:0] rx_eq_o
);
    import serdes_pkg::*;

    if (QUADS < 2 || QUADS > 8 || QUADS % 2 != 0 || LANES != 4) begin : g_bad
        $error("QUADS must be even 2..8 and LANES must be 4");
    end

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [31:0] ctl_a_q [QUADS][LANES];
    logic [`B_W-1:0] ctl_b_q [QUADS][LANES];
    logic [`RX_EQ_W-1:0] rx_q [QUADS][LANES];
    logic [`SEL_W-1:0] sel_q [QUADS];
    logic [`P_W-1:0] port_q [QUADS];
    phy_mode_t port_mode [QUADS];
    tx_setting_t [QUADS*LANES-1:0] tx_d;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic [2:0] idx;
    logic [3:0] off;
    logic in_range;
    logic quad_hit;
    logic port_hit;
    logic reg_ok;
    logic wr_en;
    logic setup;

    assign idx = apb_i.paddr[`ADDR_INDEX];
    assign off = apb_i.paddr[`ADDR_OFFSET];
    assign in_range = 32'(idx) < QUADS;
    assign quad_hit = in_range && apb_i.paddr[`ADDR_REGION] == `QUAD_REGION;
    assign port_hit = in_range && apb_i.paddr[`ADDR_REGION] == `PORT_REGION;
    assign setup = apb_i.psel && !apb_i.penable;

    always_comb begin
        reg_ok = 1'b0;
        if (quad_hit) begin
            reg_ok = off == `OFF_CTL_A || off == `OFF_CTL_B
                || off == `OFF_SEL || off == `OFF_RX_EQ;
        end else if (port_hit) begin
            reg_ok = off == `OFF_LINK_CTL2 || (off == `OFF_STATUS && !apb_i.pwrite);
        end
    end

    // Single write path for root, boot loader and management bridges
    assign wr_en = apb_i.psel && apb_i.penable && apb_i.pwrite && reg_ok;

    // Port lane number to quad lane number
    function automatic logic [1:0] quad_lane(input int q, input logic [1:0] pl);
        return REVERSED[q] ? ~pl : pl;
    endfunction

    function automatic logic lane_hit(input int q, input int l, input logic [`SEL_W-1:0] s);
        return s[`SEL_ALL] || quad_lane(q, s[`SEL_LANE]) == 2'(l);
    endfunction

    // ------------------------------------------------------------
    // Lane registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        for (int q = 0; q < QUADS; q++) begin
            for (int l = 0; l < LANES; l++) begin
                if (rst_i) begin
                    ctl_a_q[q][l] <= `CTL_A_RST;
                    ctl_b_q[q][l] <= `CTL_B_RST;
                    rx_q[q][l] <= `RX_EQ_RST;
                end else if (wr_en && quad_hit && 32'(idx) == q
                        && lane_hit(q, l, sel_q[q])) begin
                    if (off == `OFF_CTL_A) begin
                        ctl_a_q[q][l] <= apb_i.pwdata;
                    end
                    if (off == `OFF_CTL_B) begin
                        ctl_b_q[q][l] <= apb_i.pwdata[`B_W-1:0];
                    end
                    if (off == `OFF_RX_EQ) begin
                        rx_q[q][l] <= apb_i.pwdata[`RX_EQ_W-1:0];
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Quad lane select and link control two
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        for (int q = 0; q < QUADS; q++) begin
            if (rst_i) begin
                sel_q[q] <= `SEL_RST;
            end else if (wr_en && quad_hit && 32'(idx) == q && off == `OFF_SEL) begin
                sel_q[q] <= apb_i.pwdata[`SEL_W-1:0];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        for (int p = 0; p < QUADS; p++) begin
            if (rst_i) begin
                port_q[p] <= `P_RST;
            end else if (wr_en && port_hit && 32'(idx) == p && off == `OFF_LINK_CTL2) begin
                port_q[p] <= apb_i.pwdata[`P_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Bus answer, read data latched in the setup cycle
    // ------------------------------------------------------------
    logic [31:0] rdata_q;
    logic err_q;
    logic [1:0] rd_lane;

    assign rd_lane = quad_lane(32'(idx), sel_q[idx][`SEL_LANE]);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_q <= 32'h0;
            err_q <= 1'b0;
        end else if (setup) begin
            err_q <= !reg_ok;
            rdata_q <= 32'h0;
            if (reg_ok && quad_hit) begin
                case (off)
                    `OFF_CTL_A: rdata_q <= ctl_a_q[idx][rd_lane];
                    `OFF_CTL_B: rdata_q <= 32'(ctl_b_q[idx][rd_lane]);
                    `OFF_SEL: rdata_q <= 32'(sel_q[idx]);
                    default: rdata_q <= 32'(rx_q[idx][rd_lane]);
                endcase
            end else if (reg_ok && port_hit) begin
                if (off == `OFF_LINK_CTL2) begin
                    rdata_q <= 32'(port_q[idx]);
                end else begin
                    rdata_q <= 32'({gen2_i[idx], port_mode[idx]});
                end
            end
        end
    end

    always_comb begin
        apb_o.pready = apb_i.psel && apb_i.penable;
        apb_o.prdata = rdata_q;
        apb_o.pslverr = apb_i.psel && apb_i.penable && err_q;
    end

    // ------------------------------------------------------------
    // Physical mode per port
    // ------------------------------------------------------------
    always_comb begin
        for (int p = 0; p < QUADS; p++) begin
            if (port_q[p][`P_LS]) begin
                port_mode[p] = gen2_i[p] ? LS_G2 : LS_G1;
            end else if (!gen2_i[p]) begin
                port_mode[p] = FS_G1;
            end else begin
                port_mode[p] = port_q[p][`P_DEEMPH] ? FS_G2_6DB : FS_G2_3DB;
            end
        end
    end

    // ------------------------------------------------------------
    // Per-lane setting selection
    // ------------------------------------------------------------
    always_comb begin
        for (int q = 0; q < QUADS; q++) begin
            for (int l = 0; l < LANES; l++) begin
                automatic int c = q;
                automatic logic [31:0] a = ctl_a_q[q][l];
                automatic logic [`B_W-1:0] b = ctl_b_q[q][l];
                automatic tx_setting_t t = '0;
                if (q % 2 == 1 && port_q[q-1][`P_MERGE]) begin
                    c = q - 1;
                end
                t.mode = port_mode[c];
                t.margin = port_q[c][`P_MARGIN];
                t.direct_margin = port_q[c][`P_MARGIN] != `MARGIN_NORMAL;
                t.low_swing = port_q[c][`P_LS];
                t.c_slew = gen2_i[c] ? a[`A_SLC_G2] : a[`A_SLC_G1];
                t.f_slew = gen2_i[c] ? a[`A_SLF_G2] : a[`A_SLF_G1];
                case (port_mode[c])
                    FS_G1: begin
                        t.drive = b[`B_DL_G1];
                        t.c_deemph = a[`A_CDC_G1];
                        t.f_deemph = a[`A_FDC_G1];
                        t.equal = a[`A_EQ_G1];
                    end
                    FS_G2_3DB: begin
                        t.drive = b[`B_DL_G23];
                        t.c_deemph = a[`A_CDC_G23];
                        t.f_deemph = a[`A_FDC_G23];
                        t.equal = a[`A_EQ_G23];
                    end
                    FS_G2_6DB: begin
                        t.drive = b[`B_DL_G26];
                        t.c_deemph = a[`A_CDC_G26];
                        t.f_deemph = a[`A_FDC_G26];
                        t.equal = a[`A_EQ_G26];
                        t.deemph_6db = 1'b1;
                    end
                    LS_G1: begin
                        t.drive = b[`B_DL_LS1];
                    end
                    LS_G2: begin
                        t.drive = b[`B_DL_LS2];
                    end
                    default: begin
                        t.drive = b[`B_DL_G1];
                    end
                endcase
                tx_d[q*LANES+l] = t;
            end
        end
    end

    // Registered outputs, no retraining needed for updates
    always_ff @(posedge clk_i) begin
        for (int q = 0; q < QUADS; q++) begin
            for (int l = 0; l < LANES; l++) begin
                if (rst_i) begin
                    tx_o[q*LANES+l] <= '0;
                    rx_eq_o[q*LANES+l] <= `RX_EQ_RST;
                end else begin
                    tx_o[q*LANES+l] <= tx_d[q*LANES+l];
                    rx_eq_o[q*LANES+l] <= rx_q[q][l];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence rate_up_s;
        !gen2_i[0] && !port_q[0][`P_LS] ##1 gen2_i[0] && !port_q[0][`P_LS];
    endsequence

    sequence wr_b_all_s;
        wr_en && quad_hit && idx == 3'h0 && off == `OFF_CTL_B && sel_q[0][`SEL_ALL];
    endsequence

    sequence wr_a_lane0_s;
        wr_en && quad_hit && idx == 3'h0 && off == `OFF_CTL_A && sel_q[0] == 3'h0;
    endsequence

    sequence wr_rx_all_s;
        wr_en && quad_hit && idx == 3'h0 && off == `OFF_RX_EQ && sel_q[0][`SEL_ALL];
    endsequence

    ls_drive_half_a: assert property (
        $past(port_q[0][`P_LS]) && !$past(gen2_i[0])
        |-> tx_o[0].drive == $past(ctl_b_q[0][0][`B_DL_LS1]))
        else $error("low swing drive field not applied");
    ls_no_deemph_a: assert property (
        tx_o[0].low_swing |-> tx_o[0].c_deemph == 3'h0 && tx_o[0].f_deemph == 3'h0
        && tx_o[0].equal == 2'h0 && !tx_o[0].deemph_6db)
        else $error("de-emphasis active in low swing");
    ls_all_lanes_a: assert property (
        tx_o[0].low_swing == tx_o[LANES-1].low_swing)
        else $error("lanes disagree on low swing");
    margin_direct_a: assert property (
        $past(port_q[0][`P_MARGIN]) != `MARGIN_NORMAL
        |-> tx_o[0].direct_margin && tx_o[LANES-1].margin == $past(port_q[0][`P_MARGIN]))
        else $error("margin value not driven directly");
    margin_normal_a: assert property (
        $past(port_q[0][`P_MARGIN]) == `MARGIN_NORMAL |-> !tx_o[0].direct_margin)
        else $error("quad registers not in control");
    merged_pair_a: assert property (
        $past(port_q[0][`P_MERGE]) |-> tx_o[LANES].margin == $past(port_q[0][`P_MARGIN])
        && tx_o[LANES].mode == tx_o[0].mode)
        else $error("merged quad ignores lower port");
    rate_switch_a: assert property (
        rate_up_s |=> tx_o[0].mode inside {FS_G2_3DB, FS_G2_6DB})
        else $error("mode did not follow rate change");
    write_reaches_a: assert property (
        wr_b_all_s ##1 (!gen2_i[0] && port_q[0] == `P_RST)
        |=> tx_o[0].drive == $past(apb_i.pwdata[`B_DL_G1], 2))
        else $error("drive write did not reach lane");
    lane_map_a: assert property (
        wr_a_lane0_s |=> ctl_a_q[0][LANES-1] == $past(apb_i.pwdata))
        else $error("port lane 0 not mapped to quad lane 3");
    rx_eq_follow_a: assert property (
        wr_rx_all_s |-> ##2 rx_eq_o[0] == $past(apb_i.pwdata[`RX_EQ_W-1:0], 2))
        else $error("receiver equalizer write not applied");
    slew_by_rate_a: assert property (
        $past(gen2_i[0]) |-> tx_o[0].c_slew == $past(ctl_a_q[0][0][`A_SLC_G2])
        && tx_o[0].f_slew == $past(ctl_a_q[0][0][`A_SLF_G2]))
        else $error("slew fields not chosen by rate");
    deemph_6db_drive_a: assert property (
        $past(gen2_i[0]) && $past(port_q[0][`P_DEEMPH]) && !$past(port_q[0][`P_LS])
        |-> tx_o[0].deemph_6db && tx_o[0].drive == $past(ctl_b_q[0][0][`B_DL_G26]))
        else $error("six decibel field set not applied");
    fine_deemph_g1_a: assert property (
        !$past(rst_i) && $past(port_mode[0]) == FS_G1
        |-> tx_o[0].f_deemph == $past(ctl_a_q[0][0][`A_FDC_G1]))
        else $error("fine de-emphasis field not applied");

endmodule

`default_nettype wire

// file: rtl/serdes_tx_map.svh
// Purpose: Offsets, fields, reset values of the SerDes transmit setting selector
// Assumes: Included by the package and the bench
// Notes: Field macros are ranges, used as reg[`FIELD]
`ifndef SERDES_TX_MAP_SVH
`define SERDES_TX_MAP_SVH

// ------------------------------------------------------------
// Address decode
// ------------------------------------------------------------
`define APB_AW 12
`define ADDR_REGION 11:7
`define ADDR_INDEX 6:4
`define ADDR_OFFSET 3:0
`define QUAD_REGION 5'h00
`define PORT_REGION 5'h02
`define OFF_CTL_A 4'h0
`define OFF_CTL_B 4'h4
`define OFF_SEL 4'h8
`define OFF_RX_EQ 4'hc
`define OFF_LINK_CTL2 4'h0
`define OFF_STATUS 4'h4

// ------------------------------------------------------------
// Lane control A fields
// ------------------------------------------------------------
`define A_CDC_G1 2:0
`define A_CDC_G23 5:3
`define A_CDC_G26 8:6
`define A_EQ_G1 10:9
`define A_EQ_G23 12:11
`define A_EQ_G26 14:13
`define A_SLC_G1 16:15
`define A_SLF_G1 18:17
`define A_SLC_G2 20:19
`define A_SLF_G2 22:21
`define A_FDC_G1 25:23
`define A_FDC_G23 28:26
`define A_FDC_G26 31:29
`define CTL_A_RST 32'h9233_559b

// ------------------------------------------------------------
// Lane control B fields
// ------------------------------------------------------------
`define B_W 25
`define B_DL_G1 4:0
`define B_DL_G23 9:5
`define B_DL_G26 14:10
`define B_DL_LS1 19:15
`define B_DL_LS2 24:20
`define CTL_B_RST 25'h0c6_6b18

// ------------------------------------------------------------
// Lane select, receiver equalizer, link control two
// ------------------------------------------------------------
`define SEL_W 3
`define SEL_LANE 1:0
`define SEL_ALL 2
`define SEL_RST 3'h4
`define RX_EQ_W 4
`define RX_EQ_RST 4'h0
`define P_W 6
`define P_MARGIN 2:0
`define P_DEEMPH 3
`define P_LS 4
`define P_MERGE 5
`define P_RST 6'h00
`define MARGIN_NORMAL 3'h0
`define STAT_GEN2 5

`endif

// file: rtl/serdes_pkg.sv
// Purpose: Types shared by the SerDes transmit setting selector
// Assumes: serdes_tx_map.svh holds the numbers
// Notes: None
`include "serdes_tx_map.svh"
package serdes_pkg;

    typedef enum logic [4:0] {
        FS_G1 = 5'h01,
        FS_G2_3DB = 5'h02,
        FS_G2_6DB = 5'h04,
        LS_G1 = 5'h08,
        LS_G2 = 5'h10
    } phy_mode_t;

    typedef struct packed {
        logic [`APB_AW-1:0] paddr;
        logic pwrite;
        logic [31:0] pwdata;
        logic psel;
        logic penable;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_t;

    typedef struct packed {
        phy_mode_t mode;
        logic direct_margin;
        logic [2:0] margin;
        logic low_swing;
        logic deemph_6db;
        logic [4:0] drive;
        logic [1:0] equal;
        logic [2:0] c_deemph;
        logic [2:0] f_deemph;
        logic [1:0] c_slew;
        logic [1:0] f_slew;
    } tx_setting_t;

endpackage

// file: bench/serdes_lane_model.sv
// Purpose: Passive model of the SerDes transmit lanes behind the selector
// Assumes: Settings arrive registered on the core clock
// Notes: Reports the level each transmitter would launch
`timescale 1ns/10ps
`default_nettype none
module serdes_lane_model (
    // Settings from the selector
    input wire serdes_pkg::tx_setting_t [31:0] tx_i,
    // Launched level per lane
    output var logic [31:0][4:0] level_o
);
    import serdes_pkg::*;

    // ------------------------------------------------------------
    // Margin code overrides the lane drive field
    // ------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < 32; i++) begin
            level_o[i] = tx_i[i].direct_margin ? {2'b00, tx_i[i].margin} : tx_i[i].drive;
        end
    end
endmodule
`default_nettype wire

// file: bench/serdes_tx_setting_selector_bench.sv
// Purpose: Self-checking bench of the SerDes transmit setting selector
// Assumes: Zero wait state APB, one cycle from register or rate change to lanes
// Notes: Expected values come from the register map reset constants
`timescale 1ns/10ps
`default_nettype none
`include "serdes_tx_map.svh"
module serdes_tx_setting_selector_bench;
    import serdes_pkg::*;

    localparam logic [31:0] a_rst = `CTL_A_RST;
    localparam logic [24:0] b_rst = `CTL_B_RST;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    apb_req_t req = '0;
    apb_rsp_t rsp;
    logic [7:0] gen2 = 8'h00;
    tx_setting_t [31:0] tx;
    logic [31:0][3:0] rx_eq;
    logic [31:0][4:0] level;
    int n_errors = 0;
    int checks = 0;

    always #2.5 clk_i = ~clk_i;

    serdes_tx_setting_selector dut (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .apb_i(req),
        .apb_o(rsp),
        .gen2_i(gen2),
        .tx_o(tx),
        .rx_eq_o(rx_eq)
    );

    serdes_lane_model lanes (
        .tx_i(tx),
        .level_o(level)
    );

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: %s got %h want %h", $time, msg, seen, exp);
        end
    endtask

    task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        @(posedge clk_i);
        req.paddr <= a;
        req.pwrite <= w;
        req.pwdata <= d;
        req.psel <= 1'b1;
        @(posedge clk_i);
        req.penable <= 1'b1;
        @(posedge clk_i);
        while (rsp.pready !== 1'b1) begin
            @(posedge clk_i);
        end
        q = rsp.prdata;
        e = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic err);
        logic [31:0] q;
        logic e;
        xfer(a, 1'b1, d, q, e);
        chk(32'(e), 32'(err), "write response");
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic err);
        logic [31:0] q;
        logic e;
        xfer(a, 1'b0, 32'h0, q, e);
        chk(q, exp, "read data");
        chk(32'(e), 32'(err), "read response");
    endtask

    task automatic settle;
        @(posedge clk_i);
        #1;
    endtask

    task automatic rate(input logic [7:0] v);
        @(posedge clk_i);
        gen2 <= v;
        settle;
    endtask

    task automatic lane(input int i, input phy_mode_t m, input logic [4:0] dv);
        chk(32'(tx[i].mode), 32'(m), "lane mode");
        chk(32'(tx[i].drive), 32'(dv), "lane drive");
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_reset;
        rd(12'h000, a_rst, 1'b0);
        rd(12'h004, 32'(b_rst), 1'b0);
        rd(12'h008, 32'h4, 1'b0);
        for (int i = 0; i < 32; i++) lane(i, FS_G1, b_rst[`B_DL_G1]);
        chk(32'(tx[0].c_deemph), 32'(a_rst[`A_CDC_G1]), "gen1 coarse");
        $display("reset defaults done");
    endtask

    task automatic test_modes;
        rate(8'h05);
        lane(8, FS_G2_3DB, b_rst[`B_DL_G23]);
        lane(0, FS_G2_3DB, b_rst[`B_DL_G23]);
        chk(32'(tx[8].c_slew), 32'(a_rst[`A_SLC_G2]), "gen2 slew");
        wr(12'h120, 32'h8, 1'b0);
        wr(12'h100, 32'h8, 1'b0);
        settle;
        lane(9, FS_G2_6DB, b_rst[`B_DL_G26]);
        lane(0, FS_G2_6DB, b_rst[`B_DL_G26]);
        wr(12'h120, 32'h18, 1'b0);
        wr(12'h100, 32'h18, 1'b0);
        settle;
        lane(0, LS_G2, b_rst[`B_DL_LS2]);
        for (int i = 8; i < 12; i++) begin
            lane(i, LS_G2, b_rst[`B_DL_LS2]);
            chk(32'(tx[i].low_swing), 32'h1, "low swing");
            chk(32'({tx[i].c_deemph, tx[i].f_deemph, tx[i].deemph_6db}), 32'h0, "deemph");
        end
        rate(8'h00);
        lane(10, LS_G1, b_rst[`B_DL_LS1]);
        lane(0, LS_G1, b_rst[`B_DL_LS1]);
        wr(12'h120, 32'h0, 1'b0);
        wr(12'h100, 32'h0, 1'b0);
        $display("mode switching done");
    endtask

    task automatic test_lanes;
        wr(12'h008, 32'h0, 1'b0);
        wr(12'h004, {7'h0, b_rst[24:5], 5'h1f}, 1'b0);
        wr(12'h000, a_rst ^ 32'h7, 1'b0);
        wr(12'h028, 32'h0, 1'b0);
        wr(12'h024, {7'h0, b_rst[24:5], 5'h1e}, 1'b0);
        settle;
        lane(3, FS_G1, 5'h1f);
        chk(32'(tx[3].c_deemph), 32'(a_rst[`A_CDC_G1] ^ 3'h7), "lane 3 coarse");
        chk(32'(tx[0].c_deemph), 32'(a_rst[`A_CDC_G1]), "lane 0 coarse");
        lane(0, FS_G1, b_rst[4:0]);
        lane(8, FS_G1, 5'h1e);
        lane(4, FS_G1, b_rst[4:0]);
        rd(12'h004, {7'h0, b_rst[24:5], 5'h1f}, 1'b0);
        wr(12'h008, 32'h4, 1'b0);
        wr(12'h004, 32'(b_rst), 1'b0);
        wr(12'h000, a_rst, 1'b0);
        settle;
        lane(3, FS_G1, b_rst[4:0]);
        $display("lane steering done");
    endtask

    task automatic test_margin;
        wr(12'h100, 32'h5, 1'b0);
        settle;
        for (int i = 0; i < 4; i++) chk(32'(level[i]), 32'h5, "direct margin");
        chk(32'(tx[4].direct_margin), 32'h0, "unmerged quad");
        wr(12'h100, 32'h23, 1'b0);
        settle;
        for (int i = 0; i < 8; i++) chk(32'(level[i]), 32'h3, "merged margin");
        wr(12'h100, 32'h20, 1'b0);
        settle;
        chk(32'(level[5]), 32'(b_rst[4:0]), "normal range");
        wr(12'h100, 32'h0, 1'b0);
        $display("margin selection done");
    endtask

    task automatic test_rx_err;
        wr(12'h00c, 32'h9, 1'b0);
        settle;
        for (int i = 0; i < 4; i++) chk(32'(rx_eq[i]), 32'h9, "rx equalizer");
        rd(12'h00c, 32'h9, 1'b0);
        rd(12'h104, 32'h1, 1'b0);
        rd(12'h080, 32'h0, 1'b1);
        wr(12'h104, 32'h3, 1'b1);
        $display("receiver and refusal done");
    endtask

    // ------------------------------------------------------------
    // Sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        settle;
        test_reset;
        test_modes;
        test_lanes;
        test_margin;
        test_rx_err;
        final_report;
    end

    initial begin
        repeat (20000) @(posedge clk_i);
        n_errors++;
        $display("watchdog expired");
        final_report;
    end
endmodule
`default_nettype wire
